/* File: logic/xcvr_pkg.sv */
// package: constants of the configuration and timing register bank
// assumes: 200 MHz mclk, serial link clocked by the host
package xcvr_pkg;

  localparam int unsigned MCLK_PERIOD_PS  = 5000;
  localparam int unsigned OFFSET_UNIT_PS  = 295000;
  localparam int unsigned OFFSET_UNIT_CYC =
    (OFFSET_UNIT_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

  localparam logic [7:0] CFG_RESET      = 8'h22;
  localparam logic [7:0] TIMING_RESET   = 8'h00;

  localparam logic [7:0] CMD_CFG_READ   = 8'h71;
  localparam logic [7:0] CMD_TIMING_WR  = 8'h7B;
  localparam logic [7:0] CMD_CFG_WR     = 8'h7C;

  localparam int unsigned CMD_BITS      = 8;
  localparam int unsigned TIMING_BITS   = 13;
  localparam int unsigned CFG_WR_BITS   = 16;
  localparam int unsigned TIMING_FRAME  = 21;
  localparam int unsigned SHIFT_W       = 21;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned DELAY_W       = 14;

  localparam int unsigned CFG_IDLE_BIT  = 7;
  localparam int unsigned CFG_PROT_HI   = 6;
  localparam int unsigned CFG_PROT_LO   = 4;
  localparam int unsigned CFG_MOD_BIT   = 3;
  localparam int unsigned CFG_SUBC_BIT  = 2;
  localparam int unsigned CFG_RATE_BIT  = 1;
  localparam int unsigned CFG_MANB_BIT  = 0;

  localparam int unsigned TIM_SCAN_BIT  = 7;
  localparam int unsigned TIM_OFS_HI    = 6;

  typedef enum logic [2:0] {
    PROT_DIRECT,
    PROT_TAG_MODE,
    PROT_15693_1OF4,
    PROT_15693_1OF256,
    PROT_14443A,
    PROT_RSVD5,
    PROT_RSVD6,
    PROT_RSVD7
  } rf_protocol_t;

  localparam logic [2:0] PROT_FIRST_RSVD = 3'h5;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_FRAME,
    LINK_REPLY
  } link_state_t;

endpackage

/* File: logic/sclk_bit_shifter.sv */
// module: link-side bit shifter clocked by the host serial clock
// assumes: host holds resetn low over at least one serial clock rising edge
`timescale 1ns/1ps
module sclk_bit_shifter (
  input  wire logic                         serial_clk,
  input  wire logic                         resetn,
  input  wire logic                         serial_din,
  output logic [xcvr_pkg::SHIFT_W-1:0]      link_word,
  output logic                              bit_toggle
);

  ////////////////////////////////////////////////////////////////////////////
  // last bits received, newest in bit 0
  always_ff @(posedge serial_clk) begin
    if (!resetn) begin
      link_word <= '0;
    end else begin
      link_word <= {link_word[xcvr_pkg::SHIFT_W-2:0], serial_din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggles once per bit, carried to mclk as an event
  always_ff @(posedge serial_clk) begin
    if (!resetn) begin
      bit_toggle <= 1'b0;
    end else begin
      bit_toggle <= ~bit_toggle;
    end
  end

endmodule

/* File: logic/transceiver_config_timing_regs.sv */
// module: configuration and timing register bank behind the serial port
// assumes: start marker is a din fall and stop marker a din rise while
// serial clock is high; din changes only while serial clock is low
//
// How it works
// - 8-bit config: idle, depth, subcarrier, rate and decoder bypass bits.
// - config bits 6..4 pick RF protocol; codes 5 to 7 reserved.
// - config powers up at 0x22.
// - timing register sets the decoder sampling point.
// - delay counts from end of transmission to reply start.
// - timing D6..D0 is the offset, 295 ns per unit.
// - timing D7 puts boundary-scan signals on the Manchester error pin.
// - command 0x7B plus 13 data bits loads the timing register.
// - written settings stay until resetn is driven low, which reloads 0x22 and 0x00.
// - command 0x71 returns config on serial data out.
`timescale 1ns/1ps
module transceiver_config_timing_regs (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         serial_clk,
  input  wire logic         serial_din,
  output logic              serial_dout,
  input  wire logic         tx_end,
  input  wire logic         manchester_err_in,
  input  wire logic         scan_test_in,
  output logic              manchester_error_out,
  output logic              sample_strobe,
  output logic              idle_mode,
  output logic [2:0]        rf_protocol,
  output logic              protocol_reserved,
  output logic              mod_full_depth,
  output logic              one_subcarrier,
  output logic              high_data_rate,
  output logic              manchester_bypass,
  output logic [6:0]        timing_offset,
  output logic              scan_route
);

  logic [xcvr_pkg::SHIFT_W-1:0] link_word;
  logic                         bit_toggle;
  logic [2:0]                   sync1_r;
  logic [2:0]                   sync2_r;
  logic [2:0]                   sync3_r;
  logic [2:0]                   acc_r;
  logic [2:0]                   chg;
  logic                         start_ev;
  logic                         stop_ev;
  logic                         bit_ev;
  logic                         sclk_fall_ev;
  xcvr_pkg::link_state_t        state_r;
  logic [xcvr_pkg::CNT_W-1:0]   cnt_r;
  logic [2:0]                   reply_idx_r;
  logic                         reply_go_r;
  logic [7:0]                   cfg_r;
  logic [7:0]                   timing_r;
  logic [31:0]                  delay_prod;
  logic [xcvr_pkg::DELAY_W-1:0] delay_r;
  logic                         armed_r;
  logic [xcvr_pkg::DELAY_W-1:0] delay_load;

  sclk_bit_shifter u_shift (
    .serial_clk (serial_clk),
    .resetn     (resetn),
    .serial_din (serial_din),
    .link_word  (link_word),
    .bit_toggle (bit_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // three-flop synchronisers: 0 serial clock, 1 din, 2 bit toggle
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic src;
      if (gi == 0) begin : g_s0
        assign src = serial_clk;
      end else if (gi == 1) begin : g_s1
        assign src = serial_din;
      end else begin : g_s2
        assign src = bit_toggle;
      end
      always_ff @(posedge mclk) begin
        sync1_r[gi] <= src;
        sync2_r[gi] <= sync1_r[gi];
        sync3_r[gi] <= sync2_r[gi];
      end
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          acc_r[gi] <= sync3_r[gi];
        end else if (chg[gi]) begin
          acc_r[gi] <= sync3_r[gi];
        end
      end
      assign chg[gi] = (sync2_r[gi] == sync3_r[gi]) && (sync3_r[gi] != acc_r[gi]);
    end
  endgenerate

  assign start_ev     = chg[1] && !sync3_r[1] && acc_r[0];
  assign stop_ev      = chg[1] && sync3_r[1] && acc_r[0];
  assign bit_ev       = chg[2];
  assign sclk_fall_ev = chg[0] && !sync3_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= xcvr_pkg::LINK_IDLE;
    end else if (start_ev) begin
      state_r <= xcvr_pkg::LINK_FRAME;
    end else if (stop_ev) begin
      state_r <= xcvr_pkg::LINK_IDLE;
    end else begin
      case (state_r)
        xcvr_pkg::LINK_FRAME: begin
          if (bit_ev && cnt_r == 5'(xcvr_pkg::CMD_BITS - 1) &&
              link_word[7:0] == xcvr_pkg::CMD_CFG_READ) begin
            state_r <= xcvr_pkg::LINK_REPLY;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bits seen since the start marker
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (start_ev) begin
      cnt_r <= '0;
    end else if (bit_ev && state_r != xcvr_pkg::LINK_IDLE && cnt_r != '1) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration readback, msb first, one bit per serial clock fall
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reply_idx_r <= '0;
      reply_go_r  <= 1'b0;
      serial_dout <= 1'b0;
    end else if (state_r != xcvr_pkg::LINK_REPLY || start_ev || stop_ev) begin
      reply_idx_r <= '0;
      reply_go_r  <= 1'b0;
      serial_dout <= 1'b0;
    end else if (sclk_fall_ev) begin
      if (!reply_go_r || reply_idx_r != '0) begin
        serial_dout <= cfg_r[3'h7 - reply_idx_r];
        reply_idx_r <= reply_idx_r + 3'h1;
        reply_go_r  <= 1'b1;
      end else begin
        serial_dout <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register, loaded when a write frame closes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_r <= xcvr_pkg::CFG_RESET;
    end else if (stop_ev && state_r == xcvr_pkg::LINK_FRAME &&
                 cnt_r == 5'(xcvr_pkg::CFG_WR_BITS) &&
                 link_word[15:8] == xcvr_pkg::CMD_CFG_WR) begin
      cfg_r <= link_word[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing register: first 8 data bits are D7..D0, the last 5 ignored
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      timing_r <= xcvr_pkg::TIMING_RESET;
    end else if (stop_ev && state_r == xcvr_pkg::LINK_FRAME &&
                 cnt_r == 5'(xcvr_pkg::TIMING_FRAME) &&
                 link_word[20:13] == xcvr_pkg::CMD_TIMING_WR) begin
      timing_r <= link_word[12:5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response delay timer driving the decoder sampling point
  assign delay_prod = timing_r[xcvr_pkg::TIM_OFS_HI:0] * xcvr_pkg::OFFSET_UNIT_CYC;
  assign delay_load = delay_prod[xcvr_pkg::DELAY_W-1:0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      armed_r       <= 1'b0;
      delay_r       <= '0;
      sample_strobe <= 1'b0;
    end else if (tx_end) begin
      armed_r       <= 1'b1;
      delay_r       <= delay_load;
      sample_strobe <= 1'b0;
    end else if (armed_r && delay_r == '0) begin
      armed_r       <= 1'b0;
      sample_strobe <= 1'b1;
    end else begin
      delay_r       <= armed_r ? delay_r - 14'h0001 : delay_r;
      sample_strobe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manchester error pin, boundary-scan path selected by D7
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      manchester_error_out <= 1'b0;
    end else if (timing_r[xcvr_pkg::TIM_SCAN_BIT]) begin
      manchester_error_out <= scan_test_in;
    end else begin
      manchester_error_out <= manchester_err_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field outputs
  assign idle_mode         = cfg_r[xcvr_pkg::CFG_IDLE_BIT];
  assign rf_protocol       = cfg_r[xcvr_pkg::CFG_PROT_HI:xcvr_pkg::CFG_PROT_LO];
  assign protocol_reserved = rf_protocol >= xcvr_pkg::PROT_FIRST_RSVD;
  assign mod_full_depth    = cfg_r[xcvr_pkg::CFG_MOD_BIT];
  assign one_subcarrier    = cfg_r[xcvr_pkg::CFG_SUBC_BIT];
  assign high_data_rate    = cfg_r[xcvr_pkg::CFG_RATE_BIT];
  assign manchester_bypass = cfg_r[xcvr_pkg::CFG_MANB_BIT];
  assign timing_offset     = timing_r[xcvr_pkg::TIM_OFS_HI:0];
  assign scan_route        = timing_r[xcvr_pkg::TIM_SCAN_BIT];

endmodule

/* File: bench/xcvr_regs_monitor.sv */
// checker: strobe timing, error pin routing and register hold on the bank ports
// assumes: bound into transceiver_config_timing_regs, mclk domain only
`timescale 1ns/1ps
module xcvr_regs_monitor (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       serial_clk,
  input wire logic       serial_din,
  input wire logic       serial_dout,
  input wire logic       tx_end,
  input wire logic       manchester_err_in,
  input wire logic       scan_test_in,
  input wire logic       manchester_error_out,
  input wire logic       sample_strobe,
  input wire logic       idle_mode,
  input wire logic [2:0] rf_protocol,
  input wire logic       protocol_reserved,
  input wire logic [6:0] timing_offset,
  input wire logic       scan_route
);
  logic [12:0] age_r;
  logic [3:0]  rise_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // cycles since tx_end and since a stop marker
  always_ff @(posedge mclk) begin
    if (!resetn) age_r <= 13'h1FFF;
    else if (tx_end) age_r <= 13'h0001;
    else if (age_r != 13'h1FFF) age_r <= age_r + 13'h0001;
  end
  always_ff @(posedge mclk) begin
    if (!resetn) rise_r <= 4'hF;
    else if (serial_clk && $rose(serial_din)) rise_r <= 4'h0;
    else if (rise_r != 4'hF) rise_r <= rise_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  a_reserved_flag:
    assert property (protocol_reserved == (rf_protocol >= 3'h5)) else $error("reserved flag");
  a_errpin_route:
    assert property ($past(resetn) |-> manchester_error_out ==
      $past(scan_route ? scan_test_in : manchester_err_in)) else $error("error pin source");
  a_strobe_zero:
    assert property (tx_end && timing_offset == 7'h00 |-> ##2 sample_strobe) else $error("no strobe");
  a_strobe_single:
    assert property (sample_strobe |=> !sample_strobe) else $error("strobe too long");
  a_strobe_delay:
    assert property (sample_strobe |-> age_r == 13'h003B * {6'h00, timing_offset} + 13'h0002)
      else $error("strobe delay");
  a_cfg_hold:
    assert property ($changed({idle_mode, rf_protocol}) |-> rise_r <= 4'hC) else $error("cfg moved");
  a_timing_hold:
    assert property ($changed({scan_route, timing_offset}) |-> rise_r <= 4'hC)
      else $error("timing moved");
  a_dout_stop:
    assert property (serial_clk && $rose(serial_din) |-> ##[1:10] !serial_dout)
      else $error("dout not released");
  c_strobe: cover property (sample_strobe && timing_offset != 7'h00);
  c_scan: cover property (scan_route && scan_test_in);
  c_rsvd: cover property (protocol_reserved);
endmodule
bind transceiver_config_timing_regs xcvr_regs_monitor mon (.mclk, .resetn, .serial_clk,
  .serial_din, .serial_dout, .tx_end, .manchester_err_in, .scan_test_in, .manchester_error_out,
  .sample_strobe, .idle_mode, .rf_protocol, .protocol_reserved, .timing_offset, .scan_route);

/* File: bench/host_link_model.sv */
// partner: host driving the serial command port, 32 ns link clock
// assumes: link clock and din rest high between frames
`timescale 1ns/1ps
module host_link_model (
  output logic      serial_clk,
  output logic      serial_din,
  input  wire logic serial_dout
);
  initial begin
    serial_clk = 1'b1;
    serial_din = 1'b1;
  end
  // one clock pulse with din high, no marker
  task automatic pulse();
    #16 serial_clk = 1'b0;
    #16 serial_clk = 1'b1;
  endtask
  // start marker, n bits msb first from bit 20, stop marker; last bit must be 0
  task automatic frame(input logic [20:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #1.3 serial_din = 1'b0;
    #20;
    for (int i = 20; i > 20 - n; i--) begin
      serial_clk = 1'b0;
      #8 serial_din = bits[i];
      #8 serial_clk = 1'b1;
      #16;
      if (i <= 12) rd = {rd[6:0], serial_dout};
    end
    #4 serial_din = 1'b1;
    #20;
  endtask
endmodule

/* File: bench/tb.sv */
// testbench: register bank driven through the host model, ports checked
// assumes: mclk 200 MHz, resetn spans a link clock edge
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic       mclk, resetn, tx_end, manchester_err_in, scan_test_in;
  logic       serial_clk, serial_din, serial_dout, manchester_error_out, sample_strobe;
  logic       idle_mode, protocol_reserved, mod_full_depth, one_subcarrier;
  logic       high_data_rate, manchester_bypass, scan_route;
  logic [2:0] rf_protocol;
  logic [6:0] timing_offset;
  logic [7:0] cfg_w, r, d;
  int         fail_count = 0;
  int         samples_checked = 0;
  assign cfg_w = {idle_mode, rf_protocol, mod_full_depth, one_subcarrier, high_data_rate,
                  manchester_bypass};
  transceiver_config_timing_regs uut (.mclk, .resetn, .serial_clk, .serial_din, .serial_dout,
    .tx_end, .manchester_err_in, .scan_test_in, .manchester_error_out, .sample_strobe,
    .idle_mode, .rf_protocol, .protocol_reserved, .mod_full_depth, .one_subcarrier,
    .high_data_rate, .manchester_bypass, .timing_offset, .scan_route);
  host_link_model host (.serial_clk, .serial_din, .serial_dout);
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] cmd, input logic [12:0] dat, input int n);
    logic [7:0] q;
    host.frame({cmd, dat}, n, q);
    repeat (10) @(negedge mclk);
  endtask
  task automatic rd_cfg(output logic [7:0] q);
    host.frame({8'h71, 13'h0000}, 16, q);
    repeat (10) @(negedge mclk);
  endtask
  task automatic strobe(input int exp);
    int n;
    @(negedge mclk) tx_end = 1'b1;
    @(negedge mclk) tx_end = 1'b0;
    n = 0;
    while (sample_strobe !== 1'b1 && n < 9000) begin
      @(negedge mclk) n++;
    end
    if (n >= 9000) begin
      fail_count++;
      print_verdict();
    end
    `CHK(n, exp)
    @(negedge mclk) `CHK(sample_strobe, 1'b0)
  endtask
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    tx_end = 1'b0;
    manchester_err_in = 1'b0;
    scan_test_in = 1'b0;
    host.pulse();
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk) `CHK(cfg_w, 8'h22)
    `CHK({scan_route, timing_offset}, 8'h00)
    repeat (4) @(negedge mclk);
    $display("reset test done");
    for (int p = 0; p < 8; p++) begin
      d = {p[0], p[2:0], p[1], p[0], ~p[0], 1'b0};
      wr(8'h7C, {d, 5'h00}, 16);
      `CHK(cfg_w, d)
      `CHK(protocol_reserved, p >= 5)
      rd_cfg(r);
      `CHK(r, d)
    end
    $display("config test done");
    wr(8'h7B, 13'h1812, 21);
    `CHK({scan_route, timing_offset}, 8'hC0)
    @(negedge mclk) scan_test_in = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK(manchester_error_out, 1'b1)
    strobe(59 * 64 + 1);
    wr(8'h7B, 13'h00A0, 21);
    `CHK({scan_route, timing_offset}, 8'h05)
    manchester_err_in = 1'b1;
    scan_test_in = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(manchester_error_out, 1'b1)
    strobe(59 * 5 + 1);
    $display("timing test done");
    wr(8'h7B, 13'h1FE0, 20);
    wr(8'h72, 13'h1FE0, 21);
    `CHK({scan_route, timing_offset}, 8'h05)
    rd_cfg(r);
    `CHK(r, d)
    wr(8'h7B, 13'h0000, 21);
    strobe(1);
    wr(8'h7B, 13'h0FE0, 21);
    strobe(59 * 127 + 1);
    $display("refusal and range test done");
    print_verdict();
  end
endmodule
